// ==== ics_regs.sv ====
// Two-wire control/status registers with master sequencer
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ics_regs #(
  parameter int unsigned QTR = ics_pkg::QTR_CYC
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  input  wire logic [ics_pkg::AW-1:0]  awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [ics_pkg::DW-1:0]  wdata,
  input  wire logic [ics_pkg::SW-1:0]  wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [ics_pkg::AW-1:0]  araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [ics_pkg::DW-1:0]       rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic                    scl_in,
  output logic                         scl_out,
  output logic                         scl_oe,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  input  wire logic                    idle_mode,
  input  wire logic                    slave_addr_strobe,
  input  wire logic [7:0]              slave_addr_byte,
  input  wire logic                    slave_tx_begin,
  input  wire logic                    slave_rx_end,
  output logic                         slave_addr_match,
  output logic                         general_call_irq,
  output logic                         pins_enabled,
  output logic                         slew_limit_off,
  output logic                         bus_threshold_sel,
  output logic                         address_width_sel,
  output logic                         stretch_enable
);
  import ics_pkg::*;

  localparam int unsigned QW = $clog2(QTR + 1);
  localparam logic [QW-1:0] QTR_M1 = QW'(QTR - 1);
  localparam logic [QW-1:0] Q_STEP = QW'(1);

  logic            aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok;
  logic [AW-1:0]   awa_ff, nxt_awa;
  logic [DW-1:0]   wd_ff, nxt_wd, rdata_ff, nxt_rdata;
  logic [SW-1:0]   ws_ff, nxt_ws;
  logic            bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0]      bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic            wr_do, rd_do;
  logic [2:0]      wsel, rsel;
  logic [RW-1:0]   lane_mask, wv;

  logic [RW-1:0]    ctrl_ff, nxt_ctrl, stat_ff, nxt_stat;
  logic [OWN_W-1:0] own_ff, nxt_own;
  logic [7:0]       txd_ff, nxt_txd, rxd_ff, nxt_rxd, shift_ff, nxt_shift;
  ics_state_t       state_ff, nxt_state;
  logic [1:0]       phase_ff, nxt_phase;
  logic [QW-1:0]    qcnt_ff, nxt_qcnt;
  logic [3:0]       bit_ff, nxt_bit;
  logic             scl_low_ff, nxt_scl_low, sda_low_ff, nxt_sda_low;
  logic             scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic             on_q_ff, sda_q_ff, first_ff, nxt_first;
  logic             match_ff, nxt_match, gc_irq_ff, nxt_gc_irq;
  logic [1:0]       pin_s;
  logic             scl_s, sda_s, tick, run, busy, bus_start, bus_stop;

  ics_sync #(.W(2)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in ({scl_in, sda_in}),
    .sync_out (pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  function automatic logic [DW-1:0] reg_word(input logic [2:0] sel);
    case (sel)
      SEL_CTRL: reg_word = DW'(ctrl_ff);
      SEL_STAT: reg_word = DW'(stat_ff);
      SEL_OWN:  reg_word = DW'(own_ff);
      SEL_TX:   reg_word = DW'(txd_ff);
      SEL_RX:   reg_word = DW'(rxd_ff);
      default:  reg_word = '0;
    endcase
  endfunction

  assign awready = ce & ~aw_ok_ff;
  assign wready  = ce & ~w_ok_ff;
  assign arready = ce & ~rvalid_ff;
  assign wr_do   = ce & aw_ok_ff & w_ok_ff & ~bvalid_ff;
  assign rd_do   = arvalid & arready;
  assign wsel    = ics_sel(awa_ff);
  assign rsel    = ics_sel(araddr);
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  always_comb begin
    nxt_aw_ok  = aw_ok_ff;
    nxt_awa    = awa_ff;
    nxt_w_ok   = w_ok_ff;
    nxt_wd     = wd_ff;
    nxt_ws     = ws_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (awvalid && awready) begin
      nxt_aw_ok = 1'b1;
      nxt_awa   = awaddr;
    end
    if (wvalid && wready) begin
      nxt_w_ok = 1'b1;
      nxt_wd   = wdata;
      nxt_ws   = wstrb;
    end
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_do) begin
      nxt_aw_ok  = 1'b0;
      nxt_w_ok   = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
    if (rd_do) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = reg_word(rsel);
      nxt_rresp  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff  <= 1'b0;
      awa_ff    <= '0;
      w_ok_ff   <= 1'b0;
      wd_ff     <= '0;
      ws_ff     <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (ce) begin
      aw_ok_ff  <= nxt_aw_ok;
      awa_ff    <= nxt_awa;
      w_ok_ff   <= nxt_w_ok;
      wd_ff     <= nxt_wd;
      ws_ff     <= nxt_ws;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  assign run  = ctrl_ff[C_ENABLE] & ~(ctrl_ff[C_IDLEHLT] & idle_mode);
  assign busy = (state_ff != ST_IDLE) | stat_ff[S_TXFULL];
  assign tick = (qcnt_ff == '0);
  assign bus_start = scl_s & ~sda_s & sda_q_ff;
  assign bus_stop  = scl_s & sda_s & ~sda_q_ff;
  assign lane_mask = {{8{ws_ff[1]}}, {8{ws_ff[0]}}};

  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_stat    = stat_ff;
    nxt_own     = own_ff;
    nxt_txd     = txd_ff;
    nxt_rxd     = rxd_ff;
    nxt_state   = state_ff;
    nxt_phase   = phase_ff;
    nxt_qcnt    = qcnt_ff;
    nxt_bit     = bit_ff;
    nxt_shift   = shift_ff;
    nxt_scl_low = scl_low_ff;
    nxt_sda_low = sda_low_ff;
    nxt_first   = first_ff;
    nxt_match   = 1'b0;
    nxt_gc_irq  = 1'b0;
    wv = (RW'(reg_word(wsel)) & ~lane_mask) | (wd_ff[RW-1:0] & lane_mask);
    if (wr_do) begin
      case (wsel)
        SEL_CTRL: begin
          nxt_ctrl = wv & CTRL_WMASK;
          if (!ctrl_ff[C_STRETCH] && !wv[C_RELEASE]) begin
            nxt_ctrl[C_RELEASE] = ctrl_ff[C_RELEASE]; // [RULE4] [RULE10]
          end
        end
        SEL_STAT: begin
          // Only the two software-clearable flags take a written zero
          if (!wv[S_WCOL]) nxt_stat[S_WCOL] = 1'b0;
          if (!wv[S_OVF]) nxt_stat[S_OVF] = 1'b0;
        end
        SEL_OWN: nxt_own = wv[OWN_W-1:0];
        SEL_TX: begin
          if (busy) begin
            nxt_stat[S_WCOL] = 1'b1; // [RULE19]
          end else if (ws_ff[0]) begin
            nxt_txd = wd_ff[7:0];
            nxt_stat[S_TXFULL] = 1'b1; // [RULE21]
          end
        end
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (rd_do && (rsel == SEL_RX)) nxt_stat[S_RXFULL] = 1'b0; // [RULE20]
    if (slave_tx_begin) nxt_ctrl[C_RELEASE] = 1'b0; // [RULE3] [RULE4]
    if (slave_rx_end && ctrl_ff[C_STRETCH]) begin
      nxt_ctrl[C_RELEASE] = 1'b0; // [RULE3] [RULE10]
    end
    if (slave_addr_strobe && ctrl_ff[C_ENABLE]) begin
      if (slave_addr_byte == GC_ADDR) begin
        if (ctrl_ff[C_GCALL]) begin
          nxt_stat[S_GCALL] = 1'b1; // [RULE9]
          nxt_gc_irq = 1'b1; // [RULE9]
        end
      end else if (!(ctrl_ff[C_STRICT] &&
                     ics_reserved(slave_addr_byte, ctrl_ff[C_WIDE]))) begin
        nxt_match = ctrl_ff[C_WIDE] ? // [RULE5] [RULE6]
            (slave_addr_byte[7:1] == {WIDE_HDR, own_ff[9:8]}) :
            (slave_addr_byte[7:1] == own_ff[6:0]);
      end
    end
    if (bus_start) begin
      nxt_stat[S_START] = 1'b1;
      nxt_stat[S_STOP]  = 1'b0;
    end
    if (bus_stop) begin
      nxt_stat[S_STOP]  = 1'b1;
      nxt_stat[S_START] = 1'b0;
      if (!nxt_gc_irq) nxt_stat[S_GCALL] = 1'b0;
    end
    if (ctrl_ff[C_ENABLE] && !on_q_ff) nxt_stat[S_COLL] = 1'b0; // [RULE18]
    if (!ctrl_ff[C_ENABLE]) begin
      nxt_state   = ST_IDLE; // [RULE1]
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      nxt_qcnt    = QTR_M1;
    end else if (!run) begin
      nxt_state = state_ff; // [RULE2]
    end else if (state_ff == ST_IDLE) begin
      nxt_qcnt  = QTR_M1;
      nxt_phase = PH0;
      nxt_bit   = '0;
      if (ctrl_ff[C_START]) nxt_state = ST_START;
      else if (ctrl_ff[C_RESTART]) nxt_state = ST_RESTART;
      else if (ctrl_ff[C_STOP]) nxt_state = ST_STOP;
      else if (ctrl_ff[C_ACKREQ]) nxt_state = ST_ACK;
      else if (ctrl_ff[C_RECV]) nxt_state = ST_RECV;
      else if (stat_ff[S_TXFULL]) begin
        nxt_first = 1'b0;
        if (first_ff && ctrl_ff[C_STRICT] &&
            ics_reserved(txd_ff, ctrl_ff[C_WIDE])) begin
          nxt_stat[S_TXFULL] = 1'b0; // [RULE5]
        end else begin
          nxt_state = ST_XMIT;
          nxt_shift = txd_ff;
          nxt_stat[S_TXACT] = 1'b1;
        end
      end
    end else if (!tick) begin
      nxt_qcnt = qcnt_ff - Q_STEP;
    end else begin
      nxt_qcnt  = QTR_M1;
      nxt_phase = phase_ff + PH_STEP;
      case (state_ff)
        ST_START: begin
          if (phase_ff == PH0) begin
            if (!sda_s || !scl_s) nxt_state = ST_IDLE;
            else nxt_sda_low = 1'b1;
          end else begin
            nxt_scl_low = 1'b1;
            nxt_ctrl[C_START] = 1'b0; // [RULE16]
            nxt_first = 1'b1;
            nxt_state = ST_IDLE;
          end
        end
        ST_RESTART: begin
          case (phase_ff)
            PH0: nxt_sda_low = 1'b0;
            PH1: nxt_scl_low = 1'b0;
            PH2: nxt_sda_low = 1'b1;
            default: begin
              nxt_scl_low = 1'b1;
              nxt_ctrl[C_RESTART] = 1'b0; // [RULE15]
              nxt_first = 1'b1;
              nxt_state = ST_IDLE;
            end
          endcase
        end
        ST_STOP: begin
          case (phase_ff)
            PH0: nxt_sda_low = 1'b1;
            PH1: nxt_scl_low = 1'b0;
            default: begin
              nxt_sda_low = 1'b0;
              nxt_ctrl[C_STOP] = 1'b0; // [RULE14]
              nxt_state = ST_IDLE;
            end
          endcase
        end
        ST_ACK: begin
          case (phase_ff)
            PH0: nxt_sda_low = ~ctrl_ff[C_ACKVAL]; // [RULE11]
            PH1: nxt_scl_low = 1'b0;
            PH2: nxt_scl_low = 1'b1;
            default: begin
              nxt_sda_low = 1'b0;
              nxt_ctrl[C_ACKREQ] = 1'b0; // [RULE12]
              nxt_state = ST_IDLE;
            end
          endcase
        end
        ST_RECV: begin
          case (phase_ff)
            PH0: nxt_sda_low = 1'b0;
            PH1: nxt_scl_low = 1'b0;
            PH2: begin
              nxt_shift   = {shift_ff[6:0], sda_s};
              nxt_scl_low = 1'b1;
            end
            default: begin
              if (bit_ff == LAST_BIT) begin
                nxt_ctrl[C_RECV] = 1'b0; // [RULE13]
                nxt_state = ST_IDLE;
                if (stat_ff[S_RXFULL] && !(rd_do && rsel == SEL_RX)) begin
                  nxt_stat[S_OVF] = 1'b1;
                end else begin
                  nxt_rxd = shift_ff;
                  nxt_stat[S_RXFULL] = 1'b1; // [RULE20]
                end
              end else begin
                nxt_bit = bit_ff + BIT_STEP;
              end
            end
          endcase
        end
        ST_XMIT: begin
          case (phase_ff)
            PH0: nxt_sda_low = (bit_ff < ACK_BIT) ? ~shift_ff[7] : 1'b0;
            PH1: nxt_scl_low = 1'b0;
            PH2: begin
              if ((bit_ff < ACK_BIT) && !sda_low_ff && !sda_s) begin
                nxt_stat[S_COLL]   = 1'b1; // [RULE18]
                nxt_stat[S_TXFULL] = 1'b0;
                nxt_stat[S_TXACT]  = 1'b0;
                nxt_ctrl    = ctrl_ff & ~REQ_MASK;
                nxt_sda_low = 1'b0;
                nxt_state   = ST_IDLE;
              end else begin
                if (bit_ff == ACK_BIT) nxt_stat[S_ACK] = sda_s;
                nxt_shift   = {shift_ff[6:0], 1'b0};
                nxt_scl_low = 1'b1;
              end
            end
            default: begin
              if (bit_ff == ACK_BIT) begin
                nxt_stat[S_TXFULL] = 1'b0; // [RULE21]
                nxt_stat[S_TXACT]  = 1'b0;
                nxt_state = ST_IDLE;
              end else begin
                nxt_bit = bit_ff + BIT_STEP;
              end
            end
          endcase
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
    // Slave stretch holds the clock even when the master is idle
    nxt_scl_oe = nxt_ctrl[C_ENABLE] &
                 (nxt_scl_low | ~nxt_ctrl[C_RELEASE]); // [RULE1] [RULE3]
    nxt_sda_oe = nxt_ctrl[C_ENABLE] & nxt_sda_low; // [RULE1]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff    <= CTRL_RST;
      stat_ff    <= STAT_RST;
      own_ff     <= '0;
      txd_ff     <= '0;
      rxd_ff     <= '0;
      state_ff   <= ST_IDLE;
      phase_ff   <= PH0;
      qcnt_ff    <= '0;
      bit_ff     <= '0;
      shift_ff   <= '0;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      scl_oe_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
      on_q_ff    <= 1'b0;
      sda_q_ff   <= 1'b1;
      first_ff   <= 1'b0;
      match_ff   <= 1'b0;
      gc_irq_ff  <= 1'b0;
    end else if (ce) begin
      ctrl_ff    <= nxt_ctrl;
      stat_ff    <= nxt_stat;
      own_ff     <= nxt_own;
      txd_ff     <= nxt_txd;
      rxd_ff     <= nxt_rxd;
      state_ff   <= nxt_state;
      phase_ff   <= nxt_phase;
      qcnt_ff    <= nxt_qcnt;
      bit_ff     <= nxt_bit;
      shift_ff   <= nxt_shift;
      scl_low_ff <= nxt_scl_low;
      sda_low_ff <= nxt_sda_low;
      scl_oe_ff  <= nxt_scl_oe;
      sda_oe_ff  <= nxt_sda_oe;
      on_q_ff    <= ctrl_ff[C_ENABLE];
      sda_q_ff   <= sda_s;
      first_ff   <= nxt_first;
      match_ff   <= nxt_match;
      gc_irq_ff  <= nxt_gc_irq;
    end
  end

  // Open-drain: only ever pull low
  assign scl_out           = 1'b0;
  assign sda_out           = 1'b0;
  assign scl_oe            = scl_oe_ff;
  assign sda_oe            = sda_oe_ff;
  assign pins_enabled      = ctrl_ff[C_ENABLE]; // [RULE1]
  assign slew_limit_off    = ctrl_ff[C_SLEW]; // [RULE7]
  assign bus_threshold_sel = ctrl_ff[C_THRESH]; // [RULE8]
  assign address_width_sel = ctrl_ff[C_WIDE]; // [RULE6]
  assign stretch_enable    = ctrl_ff[C_STRETCH]; // [RULE10]
  assign slave_addr_match  = match_ff;
  assign general_call_irq  = gc_irq_ff;
endmodule

// ==== ics_pkg.sv ====
// Constants, types and helpers for the two-wire control and status block
// Summary of operation
// RULE1: Enable bit hands pins to bus function
// RULE2: Idle-halt bit freezes module in Idle mode
// RULE3: Stretch on: release bit writable, hardware clears
// RULE4: Stretch off: only writing one releases clock
// RULE5: Strict bit blocks reserved addresses both ways
// RULE6: Width bit picks ten or seven bit address
// RULE7: Slew-off bit drives pad slew control
// RULE8: Threshold bit drives pad input level select
// RULE9: General call raises interrupt only when enabled
// RULE10: Stretch enable gates receive-end slave clock stretching; transmit start still stretches with it off
// RULE11: Acknowledge sequence sends the ack value bit
// RULE12: Ack request runs sequence, clears when done
// RULE13: Receive request takes one byte, self-clears
// RULE14: Stop request makes Stop, then self-clears
// RULE15: Restart request makes Repeated Start, self-clears
// RULE16: Start request makes Start, then self-clears
// RULE17: Software avoids access right after disabling
// RULE18: Collision flag sets; clears on re-enable only
// RULE19: Transmit write while busy fails, flags collision
// RULE20: Receive full sets on load, clears on read
// RULE21: Transmit full sets on write, clears when sent
package ics_pkg;
  localparam int unsigned CLK_NS      = 40;
  localparam int unsigned LINK_QTR_NS = 2500;
  localparam int unsigned QTR_CYC     = (LINK_QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned AW          = 8;
  localparam int unsigned DW          = 32;
  localparam int unsigned SW          = DW / 8;
  localparam int unsigned RW          = 16;
  localparam int unsigned OWN_W       = 10;

  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STAT = 8'h04;
  localparam logic [AW-1:0] OFS_OWN  = 8'h08;
  localparam logic [AW-1:0] OFS_TX   = 8'h0C;
  localparam logic [AW-1:0] OFS_RX   = 8'h10;

  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_CTRL = 3'h1;
  localparam logic [2:0] SEL_STAT = 3'h2;
  localparam logic [2:0] SEL_OWN  = 3'h3;
  localparam logic [2:0] SEL_TX   = 3'h4;
  localparam logic [2:0] SEL_RX   = 3'h5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned C_START   = 0;
  localparam int unsigned C_RESTART = 1;
  localparam int unsigned C_STOP    = 2;
  localparam int unsigned C_RECV    = 3;
  localparam int unsigned C_ACKREQ  = 4;
  localparam int unsigned C_ACKVAL  = 5;
  localparam int unsigned C_STRETCH = 6;
  localparam int unsigned C_GCALL   = 7;
  localparam int unsigned C_THRESH  = 8;
  localparam int unsigned C_SLEW    = 9;
  localparam int unsigned C_WIDE    = 10;
  localparam int unsigned C_STRICT  = 11;
  localparam int unsigned C_RELEASE = 12;
  localparam int unsigned C_IDLEHLT = 13;
  localparam int unsigned C_ENABLE  = 15;

  localparam int unsigned S_TXFULL = 0;
  localparam int unsigned S_RXFULL = 1;
  localparam int unsigned S_START  = 3;
  localparam int unsigned S_STOP   = 4;
  localparam int unsigned S_OVF    = 6;
  localparam int unsigned S_WCOL   = 7;
  localparam int unsigned S_GCALL  = 9;
  localparam int unsigned S_COLL   = 10;
  localparam int unsigned S_TXACT  = 14;
  localparam int unsigned S_ACK    = 15;

  localparam logic [RW-1:0] CTRL_RST   = 16'h1000;
  localparam logic [RW-1:0] CTRL_WMASK = 16'hBFFF;
  localparam logic [RW-1:0] STAT_RST   = 16'h0000;
  localparam logic [RW-1:0] REQ_MASK   = 16'h001F;

  localparam logic [7:0] GC_ADDR  = 8'h00;
  localparam logic [4:0] WIDE_HDR = 5'h1E;
  localparam logic [3:0] RSV_LO   = 4'h0;
  localparam logic [3:0] RSV_HI   = 4'hF;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;

  localparam logic [1:0] PH0     = 2'h0;
  localparam logic [1:0] PH1     = 2'h1;
  localparam logic [1:0] PH2     = 2'h2;
  localparam logic [1:0] PH3     = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_START   = 7'h02,
    ST_RESTART = 7'h04,
    ST_STOP    = 7'h08,
    ST_ACK     = 7'h10,
    ST_RECV    = 7'h20,
    ST_XMIT    = 7'h40
  } ics_state_t;

  // Ten-bit headers live in the reserved space, so let them through
  function automatic logic ics_reserved(input logic [7:0] b,
                                        input logic       wide);
    ics_reserved = ((b[7:4] == RSV_LO) && (b != GC_ADDR)) ||
                   ((b[7:4] == RSV_HI) && !(wide && (b[7:3] == WIDE_HDR)));
  endfunction

  function automatic logic [2:0] ics_sel(input logic [AW-1:0] a);
    case (a)
      OFS_CTRL: ics_sel = SEL_CTRL;
      OFS_STAT: ics_sel = SEL_STAT;
      OFS_OWN:  ics_sel = SEL_OWN;
      OFS_TX:   ics_sel = SEL_TX;
      OFS_RX:   ics_sel = SEL_RX;
      default:  ics_sel = SEL_NONE;
    endcase
  endfunction
endpackage

// ==== ics_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ics_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] hold_ff;

  // Idle bus level is high, so reset to released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '1;
      hold_ff <= '1;
    end else if (ce) begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
    end
  end

  assign sync_out = hold_ff;
endmodule

// ==== ics_bus_peer.sv ====
// Far-side bus party: pull-ups, a frame clock and a data puller
`timescale 1ns/1ps
module ics_bus_peer (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  input  wire logic run,
  input  wire logic hold_sda,
  output logic      scl_in,
  output logic      sda_in
);
  logic peer_scl = 1'b1;
  // Odd offset keeps link edges off the block clock edges
  initial begin
    #7;
    forever #160 peer_scl = run ? ~peer_scl : 1'b1;
  end
  // Wired-AND with pull-ups: released lines read high
  assign scl_in = ~scl_oe & peer_scl;
  assign sda_in = ~sda_oe & ~hold_sda;
endmodule

// ==== ics_regs_sva.sv ====
// Checker for the control and status block ports
`timescale 1ns/1ps
module ics_regs_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic       scl_oe,
  input wire logic       sda_oe,
  input wire logic       pins_enabled,
  input wire logic       general_call_irq,
  input wire logic       slave_addr_strobe,
  input wire logic [7:0] slave_addr_byte
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  a_wr_answer: assert property (s_wr_taken |=> ##1 bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read data late");
  a_b_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  a_r_holds: assert property (rvalid && !rready |=> rvalid)
    else $error("read data dropped");
  a_ar_refused: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  a_off_released: assert property (
    !pins_enabled && $past(!pins_enabled) |-> !scl_oe && !sda_oe)
    else $error("pins driven while off");
  a_gcall_cause: assert property (general_call_irq |->
    $past(slave_addr_strobe) && $past(slave_addr_byte) == 8'h00)
    else $error("general call without cause");
  a_gcall_pulse: assert property (general_call_irq |=> !general_call_irq)
    else $error("general call not a pulse");
endmodule
bind ics_regs ics_regs_sva u_sva (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready,
  .scl_oe, .sda_oe, .pins_enabled, .general_call_irq, .slave_addr_strobe,
  .slave_addr_byte);

// ==== tb.sv ====
// Testbench for the two-wire control and status block
`timescale 1ns/1ps
module tb;
  import ics_pkg::*;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, scl_in, scl_out, scl_oe, sda_in;
  logic sda_out, sda_oe, idle_mode, slave_addr_strobe, slave_tx_begin;
  logic slave_rx_end, slave_addr_match, general_call_irq, pins_enabled;
  logic slew_limit_off, bus_threshold_sel, address_width_sel, stretch_enable;
  logic run, hold_sda;
  logic [7:0] awaddr, araddr, slave_addr_byte;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int fails, n_compared;
  wire [4:0] pads = {pins_enabled, address_width_sel, slew_limit_off,
                     bus_threshold_sel, stretch_enable};
  ics_regs #(.QTR(4)) u_dut (.aclk, .aresetn, .ce, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .scl_in,
    .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .idle_mode,
    .slave_addr_strobe, .slave_addr_byte, .slave_tx_begin, .slave_rx_end,
    .slave_addr_match, .general_call_irq, .pins_enabled, .slew_limit_off,
    .bus_threshold_sel, .address_width_sel, .stretch_enable);
  ics_bus_peer u_peer (.scl_oe, .sda_oe, .run, .hold_sda, .scl_in, .sda_in);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw, gb;
    @(posedge aclk);
    {ga, gw, gb} = 3'h0;
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    while (!gb) begin
      @(negedge aclk);
      {ga, gw, gb, rsp} = {ga | awready, gw | wready, bvalid, bresp};
      @(posedge aclk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ga, gr;
    @(posedge aclk);
    {ga, gr} = 2'h0;
    {araddr, arvalid, rready} <= {a, 2'h3};
    while (!gr) begin
      @(negedge aclk);
      {ga, gr, rd_v, rsp} = {ga | arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (ga) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    for (int i = 0; i == 0 || (i < 300 && rd_v[b] !== v); i++) rd(a);
    chk("poll", v, rd_v[b]);
  endtask
  task automatic kick(input logic tx);
    @(posedge aclk);
    {slave_tx_begin, slave_rx_end} <= {tx, ~tx};
    @(posedge aclk);
    {slave_tx_begin, slave_rx_end} <= 2'h0;
  endtask
  task automatic t_regs;
    rd(OFS_CTRL);
    chk("ctrl", 32'h1000, rd_v);
    wr(8'h14, 32'hFFFF);
    chk("wresp", 2'h2, rsp);
    rd(8'h14);
    chk("rresp", 32'h2, rd_v | rsp);
  endtask
  task automatic t_pads;
    wr(OFS_CTRL, 32'h9740);
    wr(OFS_CTRL, 32'h8740);
    rd(OFS_CTRL);
    chk("ctrl", 32'h8740, rd_v);
    chk("scl_hold", 1'b1, scl_oe);
    chk("pads", 5'h1F, pads);
    wr(OFS_CTRL, 32'h9740);
    kick(1'b0);
    rd(OFS_CTRL);
    chk("rx_end", 32'h8740, rd_v);
    wr(OFS_CTRL, 32'h9000);
    wr(OFS_CTRL, 32'h8000);
    rd(OFS_CTRL);
    chk("w0", 32'h9000, rd_v);
    kick(1'b1);
    rd(OFS_CTRL);
    chk("tx_beg", 32'h8000, rd_v);
  endtask
  task automatic t_gcall;
    run <= 1'b1;
    for (int g = 1; g >= 0; g--) begin
      wr(OFS_CTRL, 32'h9000 | (g << 7));
      @(posedge aclk);
      slave_addr_strobe <= 1'b1;
      @(posedge aclk);
      slave_addr_strobe <= 1'b0;
      @(negedge aclk);
      chk("gc_irq", g[0], general_call_irq);
    end
    run <= 1'b0;
  endtask
  task automatic t_seq;
    int ord[5] = '{0, 3, 4, 1, 2};
    foreach (ord[i]) begin
      wr(OFS_CTRL, 32'h9020 | (1 << ord[i]));
      poll(OFS_CTRL, ord[i], 1'b0);
      if (ord[i] == 0) chk("start", 1'b1, scl_oe);
      if (ord[i] == 2) chk("stop", 2'h0, {scl_oe, sda_oe});
      if (ord[i] == 3) begin
        poll(OFS_STAT, 1, 1'b1);
        rd(OFS_RX);
        chk("rx", 32'hFF, rd_v);
        poll(OFS_STAT, 1, 1'b0);
      end
    end
  endtask
  task automatic t_tx;
    wr(OFS_CTRL, 32'h9001);
    poll(OFS_CTRL, 0, 1'b0);
    wr(OFS_TX, 32'hFF);
    wr(OFS_TX, 32'h55);
    poll(OFS_STAT, 7, 1'b1);
    poll(OFS_STAT, 0, 1'b0);
    wr(OFS_STAT, 32'h0);
    poll(OFS_STAT, 7, 1'b0);
    hold_sda <= 1'b1;
    wr(OFS_TX, 32'hFF);
    poll(OFS_STAT, 10, 1'b1);
    hold_sda <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    @(posedge aclk); // Quiet cycle after disabling
    wr(OFS_CTRL, 32'h9000);
    poll(OFS_STAT, 10, 1'b0);
  endtask
  task automatic finish_test;
    $display("compared %0d bad %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, run} = '0;
    {slave_addr_strobe, slave_tx_begin, slave_rx_end, hold_sda, wstrb} = 8'hF;
    {awaddr, araddr, wdata, slave_addr_byte, idle_mode, ce} = 58'h1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pads();
    t_gcall();
    t_seq();
    t_tx();
    finish_test();
  end
  initial begin
    #1_000_000;
    fails++;
    finish_test();
  end
endmodule
